// [urt_cfg.svh]
// Timing and value constants for the up/down reload timer
`ifndef URT_CFG_SVH
`define URT_CFG_SVH
`define URT_CNT_W        16
`define URT_BYTE_W       8
`define URT_CNT_MAX      16'hFFFF
`define URT_BYTE_MAX     8'hFF
`define URT_CNT_RST      16'h0000
`define URT_PRE_W        4
`define URT_PRE_LAST     4'hB
`define URT_PRE_RST      4'h0
`define URT_MODE_CAPTURE 2'h0
`define URT_MODE_RELOAD  2'h1
`define URT_MODE_BAUD    2'h2
`endif

// [urt_pkg.sv]
// Types shared by the up/down reload timer modules
`include "urt_cfg.svh"
package urt_pkg;
  typedef enum logic [1:0] {
    URT_CAPTURE = `URT_MODE_CAPTURE,
    URT_RELOAD  = `URT_MODE_RELOAD,
    URT_BAUD    = `URT_MODE_BAUD
  } urt_mode_t;

  typedef struct packed {
    logic [`URT_PRE_W-1:0] pre;
    logic                  half;
    logic                  ext_s1;
    logic                  ext_s2;
    logic                  ext_s3;
    logic                  dir_s1;
    logic                  dir_s2;
    logic                  dir_s3;
    logic                  tick;
    logic                  trig_fall;
    logic                  dir_up;
  } urt_tick_st_t;

  typedef struct packed {
    logic [`URT_BYTE_W-1:0] cnt_hi;
    logic [`URT_BYTE_W-1:0] cnt_lo;
    logic [`URT_CNT_W-1:0]  reload;
    logic                   ovf;
    logic                   extf;
    logic                   irq;
    logic                   pin_o;
    logic                   pin_oe_n;
    logic                   tx_tick;
    logic                   rx_tick;
  } urt_core_st_t;
endpackage

// [urt_tick_if.sv]
// Count enable and trigger signals from the tick generator to the core
`timescale 1ns/1ps
`default_nettype none
interface urt_tick_if;
  logic tick;
  logic trig_fall;
  logic dir_up;
  modport src (output tick, output trig_fall, output dir_up);
  modport snk (input tick, input trig_fall, input dir_up);
endinterface
`default_nettype wire

// [urt_tick_gen.sv]
// Count source selection, pin synchronisers and trigger edge detection
`timescale 1ns/1ps
`default_nettype none
module urt_tick_gen
  import urt_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Configuration
  input  wire logic run,
  input  wire logic ct_sel,
  input  wire logic clkout_mode,
  // Pins
  input  wire logic ext_pin_i,
  input  wire logic dir_pin_i,
  // To core
  urt_tick_if.src   tk
);
  urt_tick_st_t st_reg;
  urt_tick_st_t st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.ext_s1 = ext_pin_i;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.ext_s3 = st_reg.ext_s2;
    st_next.dir_s1 = dir_pin_i;
    st_next.dir_s2 = st_reg.dir_s1;
    st_next.dir_s3 = st_reg.dir_s2;
    st_next.dir_up = st_reg.dir_s2;
    st_next.half   = ~st_reg.half;
    if (st_reg.pre == `URT_PRE_LAST) begin
      st_next.pre = `URT_PRE_RST;
    end else begin
      st_next.pre = st_reg.pre + 1'b1;
    end
    // RQ11 half rate clock out
    if (clkout_mode) begin
      st_next.tick = run & st_reg.half;
    // RQ2 divide by twelve
    end else if (!ct_sel) begin
      st_next.tick = run & (st_reg.pre == `URT_PRE_LAST);
    // RQ2 external pin falls
    end else begin
      st_next.tick = run & st_reg.ext_s3 & ~st_reg.ext_s2;
    end
    st_next.trig_fall = st_reg.dir_s3 & ~st_reg.dir_s2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick      = st_reg.tick;
  assign tk.trig_fall = st_reg.trig_fall;
  assign tk.dir_up    = st_reg.dir_up;
endmodule
`default_nettype wire

// [urt_timer.sv]
// Up/down auto-reload timer with capture, baud overflow and clock output
// What this block does
// RQ1 - Count is two cascaded bytes, low carries
// RQ2 - Select divide-by-twelve or external pin source
// RQ3 - Count only while run bit set
// RQ4 - Three modes chosen by clock and capture selects
// RQ5 - Direction pin sets direction when down enabled
// RQ6 - Up overflow past FFFFh sets flag, interrupt
// RQ7 - Up overflow loads reload value into count
// RQ8 - Down underflow when count equals reload value
// RQ9 - Underflow sets flag and loads FFFFh
// RQ10 - Up/down wraps toggle external flag, no interrupt
// RQ11 - Clock output counts at half rate, 50% duty
// RQ12 - Clock output reloads on overflow, no interrupt
// RQ13 - Output frequency is clock over 4(65536-reload)
// RQ14 - Generated clock driven onto external count pin
// RQ15 - Software sets up then starts clock output
// RQ16 - Baud and clock output share reload value
// RQ17 - Enabled trigger falling edge captures or reloads
// RQ18 - Transmit select routes own overflow as clock
// RQ19 - Up-only reload mode without down enable
// RQ20 - Pin inverts at each clock output overflow
`timescale 1ns/1ps
`default_nettype none
module urt_timer
  import urt_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  // Control bits
  input  wire logic                  RUN_CONTROL_BIT,
  input  wire logic                  COUNTER_TIMER_SELECT,
  input  wire logic                  CAPTURE_RELOAD_SELECT,
  input  wire logic                  RECEIVE_CLOCK_SELECT,
  input  wire logic                  TRANSMIT_CLOCK_SELECT,
  input  wire logic                  EXTERNAL_ENABLE_BIT,
  input  wire logic                  DOWN_COUNT_ENABLE,
  input  wire logic                  CLOCK_OUTPUT_ENABLE,
  // Software writes and flag clears
  input  wire logic                  COUNT_WR,
  input  wire logic [`URT_CNT_W-1:0] COUNT_WDATA,
  input  wire logic                  RELOAD_WR,
  input  wire logic [`URT_CNT_W-1:0] RELOAD_WDATA,
  input  wire logic                  OVERFLOW_FLAG_CLR,
  input  wire logic                  EXTERNAL_FLAG_CLR,
  // Pins
  input  wire logic                  EXT_COUNT_PIN_I,
  output logic                       EXT_COUNT_PIN_O,
  output logic                       EXT_COUNT_PIN_OE_N,
  input  wire logic                  EXT_DIRECTION_TRIGGER_PIN,
  // Status
  output logic [`URT_CNT_W-1:0]      COUNT,
  output logic [`URT_CNT_W-1:0]      RELOAD,
  output logic                       OVERFLOW_FLAG,
  output logic                       EXTERNAL_FLAG,
  output logic                       IRQ,
  output logic                       TX_BAUD_TICK,
  output logic                       RX_BAUD_TICK
);
  // RQ4 mode decode
  function automatic urt_mode_t mode_of(input logic rclk, input logic transmit_clock_select, input logic cprl);
    if (rclk || transmit_clock_select) begin
      mode_of = URT_BAUD;
    end else if (cprl) begin
      mode_of = URT_CAPTURE;
    end else begin
      mode_of = URT_RELOAD;
    end
  endfunction

  urt_tick_if   tk ();
  urt_core_st_t st_reg;
  urt_core_st_t st_next;
  urt_mode_t    mode;
  logic         clkout_mode;

  assign mode        = mode_of(RECEIVE_CLOCK_SELECT, TRANSMIT_CLOCK_SELECT, CAPTURE_RELOAD_SELECT);
  assign clkout_mode = CLOCK_OUTPUT_ENABLE & ~COUNTER_TIMER_SELECT;

  urt_tick_gen u_tick (
    .clk         (CLK),
    .rst         (SYS_RST),
    .run         (RUN_CONTROL_BIT),
    .ct_sel      (COUNTER_TIMER_SELECT),
    .clkout_mode (clkout_mode),
    .ext_pin_i   (EXT_COUNT_PIN_I),
    .dir_pin_i   (EXT_DIRECTION_TRIGGER_PIN),
    .tk          (tk.src)
  );

  always_comb begin
    logic [`URT_CNT_W-1:0] cnt;
    logic                  updown;
    logic                  count_up;
    logic                  wrap;
    logic                  ovf_set;
    logic                  extf_set;
    logic                  extf_tgl;
    cnt      = {st_reg.cnt_hi, st_reg.cnt_lo};
    updown   = (mode == URT_RELOAD) && DOWN_COUNT_ENABLE && !clkout_mode;
    // RQ5 direction from pin
    count_up = !updown || tk.dir_up;
    wrap     = 1'b0;
    ovf_set  = 1'b0;
    extf_set = 1'b0;
    extf_tgl = 1'b0;
    st_next         = st_reg;
    st_next.tx_tick = 1'b0;
    st_next.rx_tick = 1'b0;
    // RQ3 count only while running
    if (tk.tick) begin
      if (count_up) begin
        // RQ1 low byte carries
        st_next.cnt_lo = st_reg.cnt_lo + 1'b1;
        if (st_reg.cnt_lo == `URT_BYTE_MAX) begin
          st_next.cnt_hi = st_reg.cnt_hi + 1'b1;
        end
        // RQ6 overflow past FFFFh
        if (cnt == `URT_CNT_MAX) begin
          wrap = 1'b1;
          if (mode != URT_CAPTURE || clkout_mode) begin
            // RQ19 up-only reload too
            // RQ7 reload on overflow
            {st_next.cnt_hi, st_next.cnt_lo} = st_reg.reload;
          end
        end
      // RQ8 underflow at reload value
      end else if (cnt == st_reg.reload) begin
        wrap = 1'b1;
        // RQ9 underflow loads FFFFh
        {st_next.cnt_hi, st_next.cnt_lo} = `URT_CNT_MAX;
      end else begin
        {st_next.cnt_hi, st_next.cnt_lo} = cnt - 1'b1;
      end
    end
    // RQ12 no flag in clock output
    ovf_set = wrap && (mode != URT_BAUD) && !clkout_mode;
    // RQ10 extension bit toggles
    extf_tgl = wrap && updown;
    // RQ17 trigger capture or reload
    if (EXTERNAL_ENABLE_BIT && tk.trig_fall && mode != URT_BAUD && !updown) begin
      extf_set = 1'b1;
      if (mode == URT_CAPTURE) begin
        st_next.reload = cnt;
      end else begin
        {st_next.cnt_hi, st_next.cnt_lo} = st_reg.reload;
      end
    end
    // RQ16 baud ticks from shared reload
    if (wrap && mode == URT_BAUD) begin
      // RQ18 transmit clock routing
      st_next.tx_tick = TRANSMIT_CLOCK_SELECT;
      st_next.rx_tick = RECEIVE_CLOCK_SELECT;
    end
    // RQ13 period from reload value
    // RQ20 pin inverts each overflow
    if (wrap && clkout_mode) begin
      st_next.pin_o = ~st_reg.pin_o;
    end
    // RQ14 drive pin in clock output
    st_next.pin_oe_n = ~clkout_mode;
    if (COUNT_WR) begin
      {st_next.cnt_hi, st_next.cnt_lo} = COUNT_WDATA;
    end
    if (RELOAD_WR) begin
      st_next.reload = RELOAD_WDATA;
    end
    // RQ6 set wins over clear
    st_next.ovf = ovf_set | (st_reg.ovf & ~OVERFLOW_FLAG_CLR);
    if (extf_set) begin
      st_next.extf = 1'b1;
    end else if (extf_tgl) begin
      st_next.extf = ~st_reg.extf;
    end else if (EXTERNAL_FLAG_CLR) begin
      st_next.extf = 1'b0;
    end
    // RQ10 external flag gives no interrupt in up/down
    st_next.irq = st_next.ovf | (st_next.extf & ~updown);
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg          <= '0;
      st_reg.pin_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign COUNT              = {st_reg.cnt_hi, st_reg.cnt_lo};
  assign RELOAD             = st_reg.reload;
  assign OVERFLOW_FLAG      = st_reg.ovf;
  assign EXTERNAL_FLAG      = st_reg.extf;
  assign IRQ                = st_reg.irq;
  assign EXT_COUNT_PIN_O    = st_reg.pin_o;
  assign EXT_COUNT_PIN_OE_N = st_reg.pin_oe_n;
  assign TX_BAUD_TICK       = st_reg.tx_tick;
  assign RX_BAUD_TICK       = st_reg.rx_tick;
endmodule
`default_nettype wire

// [urt_timer_monitor.sv]
// Port checker for the up/down reload timer
`timescale 1ns/1ps
`default_nettype none
module urt_timer_monitor (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // Control and writes
  input wire logic        RUN_CONTROL_BIT,
  input wire logic        COUNTER_TIMER_SELECT,
  input wire logic        CAPTURE_RELOAD_SELECT,
  input wire logic        RECEIVE_CLOCK_SELECT,
  input wire logic        TRANSMIT_CLOCK_SELECT,
  input wire logic        EXTERNAL_ENABLE_BIT,
  input wire logic        DOWN_COUNT_ENABLE,
  input wire logic        CLOCK_OUTPUT_ENABLE,
  input wire logic        EXT_DIRECTION_TRIGGER_PIN,
  input wire logic        COUNT_WR,
  input wire logic [15:0] COUNT_WDATA,
  input wire logic        RELOAD_WR,
  // Outputs
  input wire logic        EXT_COUNT_PIN_O,
  input wire logic        EXT_COUNT_PIN_OE_N,
  input wire logic [15:0] COUNT,
  input wire logic [15:0] RELOAD,
  input wire logic        OVERFLOW_FLAG,
  input wire logic        EXTERNAL_FLAG,
  input wire logic        IRQ
);
  // Plain auto-reload, split by down-count enable
  wire logic ar = !CAPTURE_RELOAD_SELECT && !RECEIVE_CLOCK_SELECT && !TRANSMIT_CLOCK_SELECT && !CLOCK_OUTPUT_ENABLE;
  wire logic up = ar && !DOWN_COUNT_ENABLE;
  wire logic ud = ar && DOWN_COUNT_ENABLE;
  wire logic ck = CLOCK_OUTPUT_ENABLE && !COUNTER_TIMER_SELECT;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_CNT_WR: assert property (COUNT_WR |=> COUNT == $past(COUNT_WDATA))
    else $error("count write not taken");
  AST_HOLD: assert property ((!RUN_CONTROL_BIT) [*2] ##0 (!COUNT_WR && !EXTERNAL_ENABLE_BIT) |=> $stable(COUNT))
    else $error("count moved while stopped");
  AST_OVF_IRQ: assert property (OVERFLOW_FLAG |-> IRQ)
    else $error("overflow flag without request");
  AST_UP_WRAP: assert property ((up && COUNT == 16'hFFFF && !COUNT_WR && !RELOAD_WR) ##1 COUNT != 16'hFFFF
    |-> COUNT == RELOAD && OVERFLOW_FLAG) else $error("up overflow without reload");
  AST_DN_WRAP: assert property ((ud && !EXT_DIRECTION_TRIGGER_PIN && COUNT == RELOAD && !COUNT_WR && !RELOAD_WR)
    ##1 COUNT != RELOAD |-> COUNT == 16'hFFFF && OVERFLOW_FLAG && EXTERNAL_FLAG != $past(EXTERNAL_FLAG))
    else $error("underflow handled wrongly");
  AST_UD_NOIRQ: assert property ((ud && !OVERFLOW_FLAG) [*2] |-> !IRQ)
    else $error("request from external flag in up/down mode");
  AST_CK_PIN: assert property (ck [*2] |-> !EXT_COUNT_PIN_OE_N)
    else $error("clock output not driven");
  AST_CK_WRAP: assert property ((ck && COUNT == 16'hFFFF && !COUNT_WR && !RELOAD_WR) ##1 COUNT != 16'hFFFF
    |-> COUNT == RELOAD && EXT_COUNT_PIN_O != $past(EXT_COUNT_PIN_O) && !$rose(OVERFLOW_FLAG))
    else $error("clock output overflow handled wrongly");
endmodule
bind urt_timer urt_timer_monitor mon (.*);
`default_nettype wire

// [urt_timer_test.sv]
// Self-checking bench for the up/down reload timer
`timescale 1ns/1ps
`default_nettype none
module urt_timer_test;
  logic        CLK = 1'h0, SYS_RST = 1'h1, RUN_CONTROL_BIT = 1'h0, COUNTER_TIMER_SELECT = 1'h0;
  logic        CAPTURE_RELOAD_SELECT = 1'h0, RECEIVE_CLOCK_SELECT = 1'h0, TRANSMIT_CLOCK_SELECT = 1'h0;
  logic        EXTERNAL_ENABLE_BIT = 1'h0, DOWN_COUNT_ENABLE = 1'h0, CLOCK_OUTPUT_ENABLE = 1'h0;
  logic        COUNT_WR = 1'h0, RELOAD_WR = 1'h0, OVERFLOW_FLAG_CLR = 1'h0, EXTERNAL_FLAG_CLR = 1'h0;
  logic        EXT_COUNT_PIN_I = 1'h0, EXT_DIRECTION_TRIGGER_PIN = 1'h0;
  logic [15:0] COUNT_WDATA = 16'h0, RELOAD_WDATA = 16'h0, COUNT, RELOAD, n;
  logic        EXT_COUNT_PIN_O, EXT_COUNT_PIN_OE_N, OVERFLOW_FLAG, EXTERNAL_FLAG, IRQ, TX_BAUD_TICK, RX_BAUD_TICK;
  int          bad_count = 0, checks_done = 0, cycles = 0;
  localparam logic [16:0] CK_REL = 17'h0FFF0;

  urt_timer dut (.*);

  always #2.5 CLK = ~CLK;

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
      bad_count++;
    if (got !== exp)
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
  endtask

  task automatic chk_b(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
      bad_count++;
    if (got !== exp)
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
  endtask

  task automatic load(input logic [15:0] c, input logic [15:0] r);
    @(posedge CLK);
    COUNT_WR <= 1'h1;
    RELOAD_WR <= 1'h1;
    COUNT_WDATA <= c;
    RELOAD_WDATA <= r;
    @(posedge CLK);
    COUNT_WR <= 1'h0;
    RELOAD_WR <= 1'h0;
    @(negedge CLK);
    chk(COUNT, c);
    chk(RELOAD, r);
  endtask

  task automatic run(input logic v);
    @(posedge CLK);
    RUN_CONTROL_BIT <= v;
  endtask

  task automatic clr(input logic ext);
    @(posedge CLK);
    OVERFLOW_FLAG_CLR <= !ext;
    EXTERNAL_FLAG_CLR <= ext;
    @(posedge CLK);
    OVERFLOW_FLAG_CLR <= 1'h0;
    EXTERNAL_FLAG_CLR <= 1'h0;
    @(negedge CLK);
  endtask

  function automatic logic [15:0] sig(input logic p);
    return p ? {15'h0, EXT_COUNT_PIN_O} : COUNT;
  endfunction

  // Cycles between two successive changes of the count or the pin
  task automatic gap(input logic p, output logic [15:0] w);
    logic [15:0] v;
    for (int k = 0; k < 2; k++) begin
      v = sig(p);
      w = 16'h0;
      while (sig(p) === v && w < 16'h190) begin
        @(negedge CLK);
        w++;
      end
    end
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    for (int i = 0; i < 400 && COUNT !== v; i++)
      @(negedge CLK);
    chk(COUNT, v);
  endtask

  initial begin
    repeat (20) @(posedge CLK);
    SYS_RST <= 1'h0;
    @(negedge CLK);
    chk_b(EXT_COUNT_PIN_OE_N, 1'h1);
    load(16'h0000, 16'h0000);
    run(1'h1);
    gap(1'h0, n);
    chk(n, 16'hC);
    run(1'h0);
    repeat (3) @(negedge CLK);
    n = COUNT;
    repeat (40) @(negedge CLK);
    chk(COUNT, n);
    $display("timer test done");
    load(16'hFFFE, 16'h1234);
    run(1'h1);
    wait_cnt(16'h1234);
    chk_b(OVERFLOW_FLAG, 1'h1);
    chk_b(IRQ, 1'h1);
    run(1'h0);
    clr(1'h0);
    chk_b(IRQ, 1'h0);
    $display("up reload test done");
    @(posedge CLK);
    DOWN_COUNT_ENABLE <= 1'h1;
    load(16'h0012, 16'h0010);
    run(1'h1);
    wait_cnt(16'hFFFF);
    chk_b(OVERFLOW_FLAG, 1'h1);
    chk_b(EXTERNAL_FLAG, 1'h1);
    clr(1'h0);
    chk_b(IRQ, 1'h0);
    @(posedge CLK);
    EXT_DIRECTION_TRIGGER_PIN <= 1'h1;
    wait_cnt(16'h0010);
    chk_b(EXTERNAL_FLAG, 1'h0);
    run(1'h0);
    clr(1'h0);
    $display("up/down test done");
    @(posedge CLK);
    DOWN_COUNT_ENABLE <= 1'h0;
    CLOCK_OUTPUT_ENABLE <= 1'h1;
    load(CK_REL[15:0], CK_REL[15:0]);
    run(1'h1);
    gap(1'h0, n);
    chk(n, 16'h2);
    gap(1'h1, n);
    chk(n, 16'(2 * (17'h10000 - CK_REL)));
    chk_b(EXT_COUNT_PIN_OE_N, 1'h0);
    chk_b(IRQ, 1'h0);
    @(posedge CLK);
    TRANSMIT_CLOCK_SELECT <= 1'h1;
    for (int i = 0; i < 400 && TX_BAUD_TICK !== 1'h1; i++)
      @(negedge CLK);
    chk_b(TX_BAUD_TICK, 1'h1);
    chk_b(RX_BAUD_TICK, 1'h0);
    $display("clock output test done");
    run(1'h0);
    @(posedge CLK);
    TRANSMIT_CLOCK_SELECT <= 1'h0;
    CLOCK_OUTPUT_ENABLE <= 1'h0;
    CAPTURE_RELOAD_SELECT <= 1'h1;
    EXTERNAL_ENABLE_BIT <= 1'h1;
    load(16'h0055, 16'h0000);
    @(posedge CLK);
    EXT_DIRECTION_TRIGGER_PIN <= 1'h0;
    repeat (8) @(negedge CLK);
    chk(RELOAD, 16'h0055);
    chk_b(EXTERNAL_FLAG, 1'h1);
    chk_b(IRQ, 1'h1);
    chk_b(EXT_COUNT_PIN_OE_N, 1'h1);
    $display("trigger test done");
    final_report();
  end
endmodule
`default_nettype wire
